// >>> hdl/wdg_lp_pkg.sv
// constants, addresses and state codes of the low-power window watchdog
package wdg_lp_pkg;
    localparam int unsigned ADDR_W         = 8;
    localparam int unsigned DATA_W         = 8;
    localparam int unsigned CNT_W          = 7;
    localparam logic [7:0]  CTRL_ADDR      = 8'h2F;
    localparam logic [7:0]  WIN_ADDR       = 8'h30;
    localparam logic [6:0]  CNT_RST        = 7'h7F;
    localparam logic [6:0]  WIN_RST        = 7'h7F;
    localparam logic [6:0]  CNT_ONE        = 7'h01;
    localparam logic [7:0]  RDATA_ZERO     = 8'h00;
    localparam int unsigned ACT_BIT        = 7;
    localparam int unsigned TOP_BIT        = 6;
    // oscillator cycles per counter step and wake-up delays in cpu clocks
    localparam int unsigned PRESCALE_DEF   = 16384;
    localparam int unsigned WAKE_SHORT_DEF = 256;
    localparam int unsigned WAKE_LONG_DEF  = 4096;
    // chip reset pulse, typical width
    localparam int unsigned CLK_PERIOD_NS  = 100;
    localparam int unsigned RST_PULSE_NS   = 30000;
    localparam int unsigned RST_PULSE_CYC  = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        ST_RUN         = 3'b000,
        ST_HALT_LAST   = 3'b001,
        ST_HALT_FROZEN = 3'b010,
        ST_ACTIVE_HALT = 3'b011,
        ST_WAKE_DELAY  = 3'b100
    } wdg_state_t;
endpackage

// >>> hdl/window_watchdog_low_power.sv
// window watchdog with 7-bit downcounter and power-mode handling
//
// Overview of operation
// RULE_01: slow mode does not change the counter step rate.
// RULE_02: wait mode does not affect the watchdog; counter keeps decrementing.
// RULE_03: halt with timebase enable 0, halt-reset option 0 enters halt, no reset.
// RULE_04: entering plain halt, counter decrements once more, then freezes.
// RULE_05: frozen in plain halt, no watchdog reset until interrupt or reset.
// RULE_06: interrupt wake from plain halt resumes counting after 256 or 4096 clocks.
// RULE_07: reset ending plain halt returns watchdog disabled, unless hardware option.
// RULE_08: timebase enable 0, halt-reset option 1: halt gives chip reset instead.
// RULE_09: timebase enable 1: halt enters active halt, no reset, counter stopped.
// RULE_10: timebase or external interrupt leaving active halt resumes counting at once.
// RULE_11: reset ending active halt resumes counting after 256 or 4096 clocks.
// RULE_12: hardware option makes watchdog always active, activation bit ignored.
// RULE_13: software reloads counter just before halt to avoid reset after wake.
// RULE_14: counter steps every 16384 clocks, also while watchdog disabled.
// RULE_15: active watchdog resets chip when counter top bit clears (40h to 3Fh).
// RULE_16: active watchdog resets chip on reload while counter above window.
// RULE_17: software sets activation bit; it stays set until next chip reset.
// RULE_18: no interrupt request of any kind; only action is chip reset.
`timescale 1ns/10ps
module window_watchdog_low_power #(
    parameter int unsigned PRESCALE   = wdg_lp_pkg::PRESCALE_DEF,
    parameter int unsigned WAKE_SHORT = wdg_lp_pkg::WAKE_SHORT_DEF,
    parameter int unsigned WAKE_LONG  = wdg_lp_pkg::WAKE_LONG_DEF,
    parameter int unsigned PULSE_CYC  = wdg_lp_pkg::RST_PULSE_CYC
) (
    input  wire logic                            sys_clk_i,
    input  wire logic                            rst_i,
    input  wire logic [wdg_lp_pkg::ADDR_W-1:0]   addr_i,
    input  wire logic [wdg_lp_pkg::DATA_W-1:0]   wdata_i,
    input  wire logic                            wr_i,
    input  wire logic                            rd_i,
    output logic      [wdg_lp_pkg::DATA_W-1:0]   rdata_o,
    input  wire logic                            halt_req_i,
    input  wire logic                            timebase_interrupt_enable_i,
    input  wire logic                            halt_reset_option_i,
    input  wire logic                            hw_watchdog_option_i,
    input  wire logic                            wake_delay_long_i,
    input  wire logic                            timebase_irq_i,
    input  wire logic                            ext_irq_i,
    input  wire logic                            ext_reset_i,
    output logic                                 chip_reset_o,
    output logic                                 halt_mode_o,
    output logic                                 active_halt_o
);
    import wdg_lp_pkg::*;

    localparam int unsigned PRESC_W = $clog2(PRESCALE);
    localparam int unsigned DLY_W   = $clog2(WAKE_LONG + 1);
    localparam int unsigned PULSE_W = $clog2(PULSE_CYC + 1);
    localparam logic [PRESC_W-1:0] PRESC_MAX  = PRESC_W'(PRESCALE - 1);
    localparam logic [PRESC_W-1:0] PRESC_ZERO = '0;
    localparam logic [DLY_W-1:0]   DLY_SHORT  = DLY_W'(WAKE_SHORT - 1);
    localparam logic [DLY_W-1:0]   DLY_LONG   = DLY_W'(WAKE_LONG - 1);
    localparam logic [DLY_W-1:0]   DLY_ZERO   = '0;
    localparam logic [PULSE_W-1:0] PULSE_LOAD = PULSE_W'(PULSE_CYC - 1);
    localparam logic [PULSE_W-1:0] PULSE_ZERO = '0;

    // pin synchronisers: only the second stage is read
    logic ext_irq_meta_ff;
    logic ext_irq_sync_ff;
    logic ext_rst_meta_ff;
    logic ext_rst_sync_ff;

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            ext_irq_meta_ff <= 1'b0;
            ext_irq_sync_ff <= 1'b0;
            ext_rst_meta_ff <= 1'b0;
            ext_rst_sync_ff <= 1'b0;
        end else begin
            ext_irq_meta_ff <= ext_irq_i;
            ext_irq_sync_ff <= ext_irq_meta_ff;
            ext_rst_meta_ff <= ext_reset_i;
            ext_rst_sync_ff <= ext_rst_meta_ff;
        end
    end

    wdg_state_t           state_ff;
    wdg_state_t           nxt_state;
    logic [CNT_W-1:0]     cnt_ff;
    logic [CNT_W-1:0]     nxt_cnt;
    logic [CNT_W-1:0]     win_ff;
    logic [CNT_W-1:0]     nxt_win;
    logic                 act_ff;
    logic                 nxt_act;
    logic [PRESC_W-1:0]   presc_ff;
    logic [PRESC_W-1:0]   nxt_presc;
    logic [DLY_W-1:0]     delay_ff;
    logic [DLY_W-1:0]     nxt_delay;
    logic                 fire_ff;
    logic                 pulse_ff;
    logic                 nxt_pulse;
    logic [PULSE_W-1:0]   pcnt_ff;
    logic [PULSE_W-1:0]   nxt_pcnt;
    logic [DATA_W-1:0]    nxt_rdata;
    logic                 nxt_halt;
    logic                 nxt_ahalt;
    logic                 fire;
    logic                 soft_rst;
    logic                 wd_active;
    logic                 counting;
    logic                 tick;
    logic                 wr_ctrl;
    logic                 wr_win;
    logic                 halt_go;
    logic [DLY_W-1:0]     delay_load;

    assign wd_active  = act_ff | hw_watchdog_option_i; // RULE_12
    // slow and wait modes reach this block only as a slower cpu; the step stays on sys_clk_i
    assign counting   = (state_ff == ST_RUN) || (state_ff == ST_HALT_LAST); // RULE_01 RULE_02
    assign tick       = counting && (presc_ff == PRESC_MAX); // RULE_14
    assign wr_ctrl    = wr_i && !pulse_ff && (addr_i == CTRL_ADDR);
    assign wr_win     = wr_i && !pulse_ff && (addr_i == WIN_ADDR);
    assign halt_go    = halt_req_i && (state_ff == ST_RUN) && !pulse_ff;
    assign delay_load = wake_delay_long_i ? DLY_LONG : DLY_SHORT;
    // the chip reset is also this block's own reset: the cycle after it fires
    assign soft_rst   = ext_rst_sync_ff || fire_ff;

    // one reset request per pulse; a second cause during the pulse is absorbed
    always_comb begin
        fire = 1'b0;
        if (!pulse_ff && !fire_ff && !ext_rst_sync_ff) begin
            if (wd_active && counting && !cnt_ff[TOP_BIT]) begin
                fire = 1'b1; // RULE_15
            end
            if (wr_ctrl && wd_active && (cnt_ff > win_ff)) begin
                fire = 1'b1; // RULE_16
            end
            if (halt_go && !timebase_interrupt_enable_i && halt_reset_option_i) begin
                fire = 1'b1; // RULE_08
            end
        end
    end

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        nxt_win   = win_ff;
        nxt_act   = act_ff;
        nxt_presc = presc_ff;
        nxt_delay = delay_ff;
        nxt_pulse = pulse_ff;
        nxt_pcnt  = pcnt_ff;
        nxt_rdata = RDATA_ZERO;

        // prescaler only runs while the counter may step; frozen states keep its phase
        if (counting) begin
            nxt_presc = tick ? PRESC_ZERO : presc_ff + PRESC_W'(1);
        end
        if (tick) begin
            nxt_cnt = cnt_ff - CNT_ONE; // RULE_14
        end

        unique case (state_ff)
            ST_RUN: begin
                if (halt_go && timebase_interrupt_enable_i) begin
                    nxt_state = ST_ACTIVE_HALT; // RULE_09
                end else if (halt_go && !halt_reset_option_i) begin
                    nxt_state = ST_HALT_LAST; // RULE_03
                end
            end
            ST_HALT_LAST: begin
                if (ext_irq_sync_ff) begin
                    nxt_state = ST_WAKE_DELAY;
                    nxt_delay = delay_load;
                end else if (tick) begin
                    nxt_state = ST_HALT_FROZEN; // RULE_04
                end
            end
            ST_HALT_FROZEN: begin // RULE_05
                if (ext_irq_sync_ff) begin
                    nxt_state = ST_WAKE_DELAY; // RULE_06
                    nxt_delay = delay_load;
                end
            end
            ST_ACTIVE_HALT: begin
                if (timebase_irq_i || ext_irq_sync_ff) begin
                    nxt_state = ST_RUN; // RULE_10
                end
            end
            ST_WAKE_DELAY: begin
                if (delay_ff == DLY_ZERO) begin
                    nxt_state = ST_RUN;
                end else begin
                    nxt_delay = delay_ff - DLY_W'(1);
                end
            end
            default: begin
                nxt_state = ST_RUN;
            end
        endcase

        if (wr_ctrl) begin
            nxt_cnt = wdata_i[CNT_W-1:0];
            nxt_act = act_ff | wdata_i[ACT_BIT]; // RULE_17
        end
        if (wr_win) begin
            nxt_win = wdata_i[CNT_W-1:0];
        end
        if (rd_i) begin
            if (addr_i == CTRL_ADDR) begin
                nxt_rdata = {wd_active, cnt_ff};
            end else if (addr_i == WIN_ADDR) begin
                nxt_rdata = {1'b0, win_ff};
            end
        end

        if (fire) begin
            nxt_pulse = 1'b1;
            nxt_pcnt  = PULSE_LOAD;
        end else if (pulse_ff) begin
            if (pcnt_ff == PULSE_ZERO) begin
                nxt_pulse = 1'b0;
            end else begin
                nxt_pcnt = pcnt_ff - PULSE_W'(1);
            end
        end

        if (soft_rst) begin
            nxt_cnt   = CNT_RST;
            nxt_win   = WIN_RST;
            nxt_act   = 1'b0; // RULE_07
            nxt_presc = PRESC_ZERO;
            if (state_ff == ST_ACTIVE_HALT) begin
                nxt_state = ST_WAKE_DELAY; // RULE_11
                nxt_delay = delay_load;
            end else if (state_ff != ST_WAKE_DELAY) begin
                nxt_state = ST_RUN; // RULE_07
            end
        end

        nxt_halt  = (nxt_state == ST_HALT_LAST) || (nxt_state == ST_HALT_FROZEN);
        nxt_ahalt = (nxt_state == ST_ACTIVE_HALT);
    end

    // reset is the block's only action toward the cpu, no interrupt line exists
    always_ff @(posedge sys_clk_i) begin // RULE_18
        if (rst_i) begin
            state_ff      <= ST_RUN;
            cnt_ff        <= CNT_RST;
            win_ff        <= WIN_RST;
            act_ff        <= 1'b0;
            presc_ff      <= PRESC_ZERO;
            delay_ff      <= DLY_ZERO;
            fire_ff       <= 1'b0;
            pulse_ff      <= 1'b0;
            pcnt_ff       <= PULSE_ZERO;
            rdata_o       <= RDATA_ZERO;
            chip_reset_o  <= 1'b0;
            halt_mode_o   <= 1'b0;
            active_halt_o <= 1'b0;
        end else begin
            state_ff      <= nxt_state;
            cnt_ff        <= nxt_cnt;
            win_ff        <= nxt_win;
            act_ff        <= nxt_act;
            presc_ff      <= nxt_presc;
            delay_ff      <= nxt_delay;
            fire_ff       <= fire;
            pulse_ff      <= nxt_pulse;
            pcnt_ff       <= nxt_pcnt;
            rdata_o       <= nxt_rdata;
            chip_reset_o  <= nxt_pulse;
            halt_mode_o   <= nxt_halt;
            active_halt_o <= nxt_ahalt;
        end
    end

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_delay_wait;
        (state_ff == ST_WAKE_DELAY) [*8];
    endsequence

    // a chip reset in the same cycle as the halt legitimately overrides halt entry
    property p_halt_plain;
        halt_go && !timebase_interrupt_enable_i && !halt_reset_option_i && !fire
            && !ext_rst_sync_ff |=> (state_ff == ST_HALT_LAST) && halt_mode_o && !pulse_ff;
    endproperty
    a_halt_plain: assert property (p_halt_plain) else $error("plain halt not entered"); // RULE_03
    property p_halt_last_step;
        (state_ff == ST_HALT_LAST) && tick && !soft_rst && !ext_irq_sync_ff
            |=> (state_ff == ST_HALT_FROZEN) && (cnt_ff == $past(cnt_ff) - CNT_ONE);
    endproperty
    a_halt_last_step: assert property (p_halt_last_step) else $error("halt last step wrong"); // RULE_04
    property p_frozen_quiet;
        (state_ff == ST_HALT_FROZEN) && !soft_rst && !ext_irq_sync_ff
            |=> $stable(cnt_ff) && !fire_ff;
    endproperty
    a_frozen_quiet: assert property (p_frozen_quiet) else $error("frozen counter moved"); // RULE_05
    property p_halt_wake_delay;
        (state_ff == ST_HALT_FROZEN) && ext_irq_sync_ff && !soft_rst
            |=> s_delay_wait ##0 $stable(cnt_ff);
    endproperty
    a_halt_wake_delay: assert property (p_halt_wake_delay) else $error("no wake delay"); // RULE_06
    property p_halt_reset_opt;
        halt_go && !timebase_interrupt_enable_i && halt_reset_option_i && !fire_ff
            && !ext_rst_sync_ff |=> ##1 chip_reset_o && (state_ff == ST_RUN);
    endproperty
    a_halt_reset_opt: assert property (p_halt_reset_opt) else $error("halt did not reset"); // RULE_08
    property p_active_halt_stop;
        (state_ff == ST_ACTIVE_HALT) && !soft_rst |=> $stable(cnt_ff) && !fire_ff;
    endproperty
    a_active_halt_stop: assert property (p_active_halt_stop) else $error("counter ran"); // RULE_09
    // the cpu may halt again right away, so only the first cycle after wake is checked
    property p_active_halt_wake;
        (state_ff == ST_ACTIVE_HALT) && (timebase_irq_i || ext_irq_sync_ff) && !soft_rst
            |=> (state_ff == ST_RUN) && !active_halt_o;
    endproperty
    a_active_halt_wake: assert property (p_active_halt_wake) else $error("slow wake"); // RULE_10
    property p_active_halt_reset;
        (state_ff == ST_ACTIVE_HALT) && soft_rst |=> s_delay_wait;
    endproperty
    a_active_halt_reset: assert property (p_active_halt_reset) else $error("no delay"); // RULE_11
    property p_run_step;
        (state_ff == ST_RUN) && tick && !soft_rst && !wr_ctrl
            |=> cnt_ff == $past(cnt_ff) - CNT_ONE;
    endproperty
    a_run_step: assert property (p_run_step) else $error("counter missed step"); // RULE_14
    property p_top_bit_reset;
        wd_active && counting && !cnt_ff[TOP_BIT] && !pulse_ff && !fire_ff && !ext_rst_sync_ff
            |=> fire_ff ##1 chip_reset_o;
    endproperty
    a_top_bit_reset: assert property (p_top_bit_reset) else $error("no timeout reset"); // RULE_15
    property p_window_reset;
        wr_ctrl && wd_active && (cnt_ff > win_ff) && !fire_ff && !ext_rst_sync_ff
            |=> fire_ff ##1 chip_reset_o;
    endproperty
    a_window_reset: assert property (p_window_reset) else $error("no window reset"); // RULE_16
    property p_act_sticky;
        act_ff && !soft_rst |=> act_ff;
    endproperty
    a_act_sticky: assert property (p_act_sticky) else $error("activation lost"); // RULE_17
endmodule

// >>> verif/testbench.sv
// self-checking bench for the low-power window watchdog
`timescale 1ns/10ps
module testbench;
    import wdg_lp_pkg::*;
    localparam int PRE = 16;
    localparam int WS  = 8;
    localparam int WL  = 40;
    localparam int PW  = 4;
    // selectors of the k-cycle input pulses
    localparam int P_HALT = 0;
    localparam int P_TBI  = 1;
    localparam int P_EXI  = 2;
    localparam int P_EXR  = 3;
    logic       sys_clk_i = 1'b0;
    logic       rst_i     = 1'b1;
    logic [7:0] addr_i    = 8'h00;
    logic [7:0] wdata_i   = 8'h00;
    logic       wr_i      = 1'b0;
    logic       rd_i      = 1'b0;
    logic       halt_req_i = 1'b0;
    logic       tb_en     = 1'b0;
    logic       halt_opt  = 1'b0;
    logic       hw_opt    = 1'b0;
    logic       wlong     = 1'b0;
    logic       tb_irq    = 1'b0;
    logic       ext_irq   = 1'b0;
    logic       ext_rst   = 1'b0;
    logic [7:0] rdata_o;
    logic       chip_reset_o;
    logic       halt_mode_o;
    logic       active_halt_o;
    int         errors = 0;
    int         n_compared = 0;
    int         cycles = 0;
    logic [7:0] v0;
    logic [7:0] v1;
    int         n;

    window_watchdog_low_power #(.PRESCALE(PRE), .WAKE_SHORT(WS), .WAKE_LONG(WL),
                                .PULSE_CYC(PW)) u_dut (
        .sys_clk_i                   (sys_clk_i),
        .rst_i                       (rst_i),
        .addr_i                      (addr_i),
        .wdata_i                     (wdata_i),
        .wr_i                        (wr_i),
        .rd_i                        (rd_i),
        .rdata_o                     (rdata_o),
        .halt_req_i                  (halt_req_i),
        .timebase_interrupt_enable_i (tb_en),
        .halt_reset_option_i         (halt_opt),
        .hw_watchdog_option_i        (hw_opt),
        .wake_delay_long_i           (wlong),
        .timebase_irq_i              (tb_irq),
        .ext_irq_i                   (ext_irq),
        .ext_reset_i                 (ext_rst),
        .chip_reset_o                (chip_reset_o),
        .halt_mode_o                 (halt_mode_o),
        .active_halt_o               (active_halt_o)
    );

    always #50 sys_clk_i = ~sys_clk_i;

    // whole run needs well under a thousand cycles
    always @(posedge sys_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors = errors + 1;
            final_report();
        end
    end

    task automatic cyc(input int k);
        repeat (k) @(posedge sys_clk_i);
    endtask

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared = n_compared + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic do_reset();
        @(posedge sys_clk_i);
        rst_i <= 1'b1;
        cyc(10);
        rst_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge sys_clk_i);
        wr_i    <= 1'b0;
    endtask

    // data stand only in the cycle after the strobe edge
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge sys_clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge sys_clk_i);
        rd_i   <= 1'b0;
        #1;
        v = rdata_o;
    endtask

    // a selector instead of a ref argument: nonblocking writes stay on module variables
    task automatic drive(input int sel, input logic v);
        case (sel)
            P_HALT: halt_req_i <= v;
            P_TBI: tb_irq <= v;
            P_EXI: ext_irq <= v;
            default: ext_rst <= v;
        endcase
    endtask

    task automatic pulse(input int sel, input int k);
        @(posedge sys_clk_i);
        drive(sel, 1'b1);
        cyc(k);
        drive(sel, 1'b0);
    endtask

    // cycles until chip reset rises, lim+1 if it never does
    task automatic fire(input int lim, output int t);
        t = lim + 1;
        for (int i = 1; i <= lim; i++) begin
            @(posedge sys_clk_i);
            #1;
            if (chip_reset_o === 1'b1) begin
                t = i;
                break;
            end
        end
    endtask

    task automatic final_report();
        if (errors == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        do_reset();
        rd(CTRL_ADDR, v0);
        chk("ctrl_rst", v0, 8'h7F);
        rd(WIN_ADDR, v0);
        chk("win_rst", v0, 8'h7F);
        rd(8'h31, v0);
        chk("unmapped", v0, 8'h00);
        // any span of 3*PRE edges holds exactly three steps, whatever the phase
        rd(CTRL_ADDR, v0);
        cyc(3 * PRE - 2);
        rd(CTRL_ADDR, v1);
        chk("free_run", v0 - v1, 8'h03);
        wr(CTRL_ADDR, 8'hFF);
        wr(CTRL_ADDR, 8'h7E);
        rd(CTRL_ADDR, v0);
        chk("act_sticky", v0 & 8'h80, 8'h80);
        wr(WIN_ADDR, 8'hFF);
        rd(WIN_ADDR, v0);
        chk("win_bit7", v0, 8'h7F);
        // timeout: 41h -> 40h -> 3Fh, then a fixed pulse and a cleared activation
        do_reset();
        wr(CTRL_ADDR, 8'hC1);
        fire(3 * PRE, n);
        chk("timeout", 8'(n > PRE && n <= 2 * PRE + 3), 8'h01);
        n = 0;
        while (chip_reset_o === 1'b1 && n < 20) begin
            @(posedge sys_clk_i);
            #1;
            n++;
        end
        chk("pulse_w", 8'(n), 8'(PW));
        rd(CTRL_ADDR, v0);
        chk("act_clr", v0 & 8'h80, 8'h00);
        // reload above the window limit
        do_reset();
        wr(WIN_ADDR, 8'h50);
        wr(CTRL_ADDR, 8'hFF);
        wr(CTRL_ADDR, 8'hFF);
        fire(4, n);
        chk("win_fire", 8'(n <= 4), 8'h01);
        // hardware option: active without the bit
        hw_opt <= 1'b1;
        do_reset();
        rd(CTRL_ADDR, v0);
        chk("hw_act", v0, 8'hFF);
        wr(CTRL_ADDR, 8'h3F);
        fire(4, n);
        chk("hw_fire", 8'(n <= 4), 8'h01);
        hw_opt <= 1'b0;
        // halt gives a reset even with the watchdog idle
        halt_opt <= 1'b1;
        do_reset();
        pulse(P_HALT, 1);
        fire(4, n);
        chk("halt_rst", 8'(n <= 4), 8'h01);
        chk("no_halt", halt_mode_o, 8'h00);
        // active halt: frozen, no reset, immediate resume
        tb_en <= 1'b1;
        do_reset();
        wr(CTRL_ADDR, 8'hFF);
        pulse(P_HALT, 1);
        rd(CTRL_ADDR, v0);
        cyc(4 * PRE);
        rd(CTRL_ADDR, v1);
        chk("ah_frozen", v1, v0);
        chk("ah_mode", active_halt_o, 8'h01);
        chk("ah_norst", chip_reset_o, 8'h00);
        pulse(P_TBI, 1);
        cyc(2);
        chk("ah_exit", active_halt_o, 8'h00);
        rd(CTRL_ADDR, v0);
        cyc(2 * PRE - 2);
        rd(CTRL_ADDR, v1);
        chk("ah_resume", v0 - v1, 8'h02);
        // external interrupt also leaves active halt at once
        pulse(P_HALT, 1);
        pulse(P_EXI, 1);
        cyc(4);
        chk("ah_ext", active_halt_o, 8'h00);
        // reset out of active halt holds the counter for the long delay
        wlong <= 1'b1;
        pulse(P_HALT, 1);
        pulse(P_EXR, 1);
        cyc(4);
        chk("ah_rst", active_halt_o, 8'h00);
        rd(CTRL_ADDR, v0);
        cyc(PRE + 4);
        rd(CTRL_ADDR, v1);
        chk("ah_delay", v1, 8'h7F);
        tb_en    <= 1'b0;
        halt_opt <= 1'b0;
        // plain halt: one more step, frozen, delayed resume, for both delays
        for (int lg = 0; lg < 2; lg++) begin
            wlong <= lg[0];
            do_reset();
            wr(CTRL_ADDR, 8'hC1);
            pulse(P_HALT, 1);
            fire(5 * PRE, n);
            chk("halt_norst", 8'(n), 8'(5 * PRE + 1));
            chk("halt_mode", halt_mode_o, 8'h01);
            rd(CTRL_ADDR, v0);
            chk("halt_step", v0, 8'hC0);
            // counter froze right after a step, so a full step follows the wake delay
            pulse(P_EXI, 1);
            fire((lg ? WL : WS) + PRE + 8, n);
            chk("wake_at", 8'(n > (lg ? WL : WS) + PRE), 8'h01);
            chk("wake_fire", 8'(n <= (lg ? WL : WS) + PRE + 8), 8'h01);
        end
        // reset out of plain halt disables the watchdog
        do_reset();
        wr(CTRL_ADDR, 8'hFF);
        pulse(P_HALT, 1);
        pulse(P_EXR, 2);
        cyc(4);
        chk("hr_mode", halt_mode_o, 8'h00);
        rd(CTRL_ADDR, v0);
        chk("hr_ctrl", v0, 8'h7F);
        final_report();
    end
endmodule
